// ---- design/hsc_pkg.sv ----
// Constants, types and routing tables for the high-speed counter bank.
// Assumes a single 100 MHz clock and pins already synchronous to it.
package hsc_pkg;

	// ==========================================================
	// Sizes and indices
	localparam int NUM_CTR = 5;
	localparam int NUM_PIN = 8;
	localparam int NUM_SLOT = 32;
	localparam int NUM_RELAY = 16;
	localparam int CTR_FIRST = 0;
	localparam int CTR_SECOND = 1;
	localparam int CTR_DUAL = 2;
	localparam int CTR_QUAD = 3;
	localparam int CTR_QUAD_RST = 4;
	localparam logic [5:0] SLOT_LIMIT = 6'h20;
	localparam logic signed [31:0] VALUE_RST = 32'sh0;
	localparam logic [15:0] ZONE_MASK = 16'h0007;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SW_PERIOD_NS = 100;
	localparam int SW_LIMITED_PERIOD_NS = 200;
	localparam logic [7:0] SW_GAP_CYC =
		8'((SW_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] SW_LIMITED_GAP_CYC =
		8'((SW_LIMITED_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		MODE_SINGLE = 3'b001,
		MODE_DUAL = 3'b010,
		MODE_QUAD = 3'b100
	} ctr_mode_t;

	typedef enum logic [3:0] {
		KIND_SET = 4'b0001,
		KIND_RESET = 4'b0010,
		KIND_ZONE = 4'b0100,
		KIND_TABLE = 4'b1000
	} cmp_kind_t;

	typedef struct packed {
		ctr_mode_t mode;
		logic [2:0] pin_a;
		logic [2:0] pin_b;
		logic [2:0] pin_r;
		logic [2:0] pin_s;
		logic rst_en;
		logic start_en;
	} ctr_route_t;

	typedef struct packed {
		cmp_kind_t kind;
		logic [2:0] ctr;
		logic [3:0] relay;
		logic signed [31:0] lo;
		logic signed [31:0] hi;
	} cmp_req_t;

	// ==========================================================
	// Input routing per counter
	localparam ctr_route_t ROUTE_FIRST_STD =
		'{MODE_SINGLE, 3'h0, 3'h0, 3'h1, 3'h6, 1'b1, 1'b1};
	localparam ctr_route_t ROUTE_FIRST_ALT =
		'{MODE_SINGLE, 3'h6, 3'h6, 3'h0, 3'h0, 1'b0, 1'b0};
	localparam ctr_route_t ROUTE_SECOND_STD =
		'{MODE_SINGLE, 3'h2, 3'h2, 3'h3, 3'h7, 1'b1, 1'b1};
	localparam ctr_route_t ROUTE_SECOND_ALT =
		'{MODE_SINGLE, 3'h7, 3'h7, 3'h0, 3'h0, 1'b0, 1'b0};
	localparam ctr_route_t ROUTE_DUAL_STD =
		'{MODE_DUAL, 3'h3, 3'h4, 3'h5, 3'h0, 1'b1, 1'b0};
	localparam ctr_route_t ROUTE_DUAL_ALT =
		'{MODE_DUAL, 3'h3, 3'h4, 3'h5, 3'h0, 1'b0, 1'b0};
	localparam ctr_route_t ROUTE_QUAD =
		'{MODE_QUAD, 3'h0, 3'h1, 3'h0, 3'h0, 1'b0, 1'b0};
	localparam ctr_route_t ROUTE_QUAD_RST_STD =
		'{MODE_QUAD, 3'h3, 3'h4, 3'h5, 3'h0, 1'b1, 1'b0};
	localparam ctr_route_t ROUTE_QUAD_RST_ALT =
		'{MODE_QUAD, 3'h3, 3'h4, 3'h5, 3'h0, 1'b0, 1'b0};

endpackage

// ---- design/counter_unit.sv ----
// One high-speed counter: input decode, reset, rate limit, value hold.
// Assumes pins are synchronous and route changes only between pulses.
`timescale 1ns/1ps
module counter_unit (
	input wire logic sys_clk,
	input wire logic resetn,
	input hsc_pkg::ctr_route_t route,
	input wire logic [7:0] pins,
	input wire logic enable,
	input wire logic is_sw,
	input wire logic rst_inv,
	input wire logic dir_down_sel,
	input wire logic four_edge,
	input wire logic [7:0] min_gap,
	input wire logic refresh,
	output logic signed [31:0] live_r,
	output logic signed [31:0] vis_r,
	output logic step_r,
	output logic dir_down_r
);

	logic [7:0] pins_q;
	logic [7:0] gap_r;
	logic a, b, a_q, b_q, a_rise, a_chg, b_chg;
	logic rst_lvl, rst_lvl_q, rst_hit, start_ok, accept;
	logic up, dn, go;
	logic signed [31:0] live_nxt;

	assign a = pins[route.pin_a];
	assign b = pins[route.pin_b];
	assign a_q = pins_q[route.pin_a];
	assign b_q = pins_q[route.pin_b];
	assign a_rise = a & ~a_q;
	assign a_chg = a ^ a_q;
	assign b_chg = b ^ b_q;
	assign start_ok = ~route.start_en | pins[route.pin_s];
	// clear on turning on; inverted level clears on turning off
	assign rst_lvl = pins[route.pin_r] ^ rst_inv;
	assign rst_lvl_q = pins_q[route.pin_r] ^ rst_inv;
	assign rst_hit = route.rst_en & rst_lvl & ~rst_lvl_q;
	// rate limit, only software counters lose fast pulses
	assign accept = ~is_sw | (gap_r >= min_gap);
	assign go = enable & start_ok & accept & (up ^ dn);

	// ==========================================================
	// Pulse decode
	always_comb begin
		up = 1'b0;
		dn = 1'b0;
		case (route.mode)
			hsc_pkg::MODE_SINGLE: begin
				up = a_rise & ~dir_down_sel;
				dn = a_rise & dir_down_sel;
			end
			hsc_pkg::MODE_DUAL: begin
				up = a_rise;
				dn = b & ~b_q;
			end
			hsc_pkg::MODE_QUAD: begin
				// one or four edges per cycle of A and B
				if (four_edge) begin
					up = (a_chg & (a ^ b)) | (b_chg & ~(a ^ b));
					dn = (a_chg & ~(a ^ b)) | (b_chg & (a ^ b));
				end else begin
					up = a_rise & ~b;
					dn = a_rise & b;
				end
			end
			default: begin
				up = 1'b0;
				dn = 1'b0;
			end
		endcase
	end

	// step by direction, reset takes priority
	always_comb begin
		live_nxt = live_r;
		if (rst_hit)
			live_nxt = hsc_pkg::VALUE_RST;
		else if (go && up)
			live_nxt = live_r + 32'sd1;
		else if (go && dn)
			live_nxt = live_r - 32'sd1;
	end

	// ==========================================================
	// State
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pins_q <= 8'h00;
			gap_r <= 8'hff;
		end else begin
			pins_q <= pins;
			if (go)
				gap_r <= 8'h01;
			else if (gap_r != 8'hff)
				gap_r <= gap_r + 8'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			live_r <= hsc_pkg::VALUE_RST;
			step_r <= 1'b0;
			dir_down_r <= 1'b0;
		end else begin
			live_r <= live_nxt;
			step_r <= go | rst_hit;
			if (go)
				dir_down_r <= dn;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			vis_r <= hsc_pkg::VALUE_RST;
		end else if (is_sw) begin
			vis_r <= live_nxt;
		end else if (refresh) begin
			// whole word copied in one edge
			vis_r <= live_r;
		end
	end

endmodule

// ---- design/compare_slot.sv ----
// One high-speed compare entry, evaluated on each step of its counter.
// Assumes the caller muxes the targeted counter's value and step in.
`timescale 1ns/1ps
module compare_slot (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic clear,
	input hsc_pkg::cmp_req_t req,
	input wire logic signed [31:0] value,
	input wire logic step,
	output logic used_r,
	output hsc_pkg::cmp_req_t ent_r,
	output logic [15:0] drv_mask,
	output logic [15:0] drv_val
);

	logic [15:0] one;
	logic [2:0] zone_pat;

	assign one = 16'h0001 << ent_r.relay;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			used_r <= 1'b0;
			ent_r <= '0;
		end else if (clear) begin
			used_r <= 1'b0;
		end else if (load) begin
			used_r <= 1'b1;
			ent_r <= req;
		end
	end

	// evaluated on the counting step itself
	always_comb begin
		drv_mask = 16'h0000;
		drv_val = 16'h0000;
		zone_pat = 3'b100;
		if (value < ent_r.lo)
			zone_pat = 3'b001;
		else if (value <= ent_r.hi)
			zone_pat = 3'b010;
		if (used_r && step) begin
			case (ent_r.kind)
				hsc_pkg::KIND_SET: begin
					drv_mask = (value == ent_r.lo) ? one : 16'h0000;
					drv_val = drv_mask;
				end
				hsc_pkg::KIND_RESET: begin
					drv_mask = (value == ent_r.lo) ? one : 16'h0000;
				end
				hsc_pkg::KIND_ZONE: begin
					drv_mask = hsc_pkg::ZONE_MASK << ent_r.relay;
					drv_val = {13'h0000, zone_pat} << ent_r.relay;
				end
				hsc_pkg::KIND_TABLE: begin
					if (value == ent_r.lo) begin
						drv_mask = one;
						drv_val = one;
					end else if (value == ent_r.hi) begin
						drv_mask = one;
					end
				end
				default: begin
					drv_mask = 16'h0000;
					drv_val = 16'h0000;
				end
			endcase
		end
	end

endmodule

// ---- design/high_speed_counter_control.sv ----
// Top of the high-speed counter bank: five counters, 32 compare slots,
// function switching, direction and operation-status flags.
// Assumes program-side flags and instruction strobes come from a scan
// engine on the same clock, and counter pins are already synchronous.
`timescale 1ns/1ps
module high_speed_counter_control (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] ctr_pins,
	input wire logic plc_run,
	input wire logic function_change_master_flag,
	input wire logic reset_polarity_flag,
	input wire logic first_started_counter_switch,
	input wire logic second_started_counter_switch,
	input wire logic dual_counter_switch,
	input wire logic edge_mode_flag_pair_a,
	input wire logic edge_mode_flag_pair_b,
	input wire logic direction_select_flag_first,
	input wire logic direction_select_flag_second,
	input wire logic [4:0] ctr_enable,
	input wire logic [4:0] out_instr,
	input wire logic [4:0] current_value_fetch_instr,
	input wire logic cmp_load,
	input hsc_pkg::cmp_req_t cmp_req,
	output logic [4:0][31:0] cur_value,
	output logic [15:0] out_relay_r,
	output logic direction_monitor_flag_dual,
	output logic direction_monitor_flag_quad,
	output logic direction_monitor_flag_quad_reset,
	output logic op_status_flag_channel0,
	output logic op_status_flag_channel2,
	output logic op_status_flag_channel3,
	output logic [4:0] sw_mode_r,
	output logic freq_limited_r,
	output logic cmp_refused_r
);

	// ==========================================================
	// Declarations
	logic run_q;
	logic run_start;
	logic master;
	logic alt_first, alt_second, alt_dual, rst_inv;
	logic [4:0] cmp_target_r;
	logic table_used_r;
	logic [5:0] ld_ptr_r;
	logic accept;
	logic [7:0] min_gap;
	hsc_pkg::ctr_route_t route [hsc_pkg::NUM_CTR];
	logic [4:0] dir_sel;
	logic [4:0] four_edge;
	logic signed [31:0] live [hsc_pkg::NUM_CTR];
	logic [4:0] step;
	logic [4:0] dir_dn;
	logic [4:0] sw_nxt;
	logic [hsc_pkg::NUM_SLOT-1:0] slot_used;
	hsc_pkg::cmp_req_t slot_ent [hsc_pkg::NUM_SLOT];
	logic [15:0] slot_mask [hsc_pkg::NUM_SLOT];
	logic [15:0] slot_val [hsc_pkg::NUM_SLOT];
	logic [15:0] mask_any;
	logic [15:0] val_any;

	assign run_start = plc_run & ~run_q;
	// switches act only under the master flag
	assign master = function_change_master_flag;
	assign alt_first = master & first_started_counter_switch;
	assign alt_second = master & second_started_counter_switch;
	// one switch alters both counters together
	assign alt_dual = master & dual_counter_switch;
	// polarity needs the master flag as well
	assign rst_inv = master & reset_polarity_flag;

	// ==========================================================
	// Routing and per-counter controls
	always_comb begin
		route[hsc_pkg::CTR_FIRST] = alt_first ?
			hsc_pkg::ROUTE_FIRST_ALT : hsc_pkg::ROUTE_FIRST_STD;
		route[hsc_pkg::CTR_SECOND] = alt_second ?
			hsc_pkg::ROUTE_SECOND_ALT : hsc_pkg::ROUTE_SECOND_STD;
		route[hsc_pkg::CTR_DUAL] = alt_dual ?
			hsc_pkg::ROUTE_DUAL_ALT : hsc_pkg::ROUTE_DUAL_STD;
		route[hsc_pkg::CTR_QUAD] = hsc_pkg::ROUTE_QUAD;
		route[hsc_pkg::CTR_QUAD_RST] = alt_dual ?
			hsc_pkg::ROUTE_QUAD_RST_ALT : hsc_pkg::ROUTE_QUAD_RST_STD;
	end

	// only single-input counters take a direction select
	assign dir_sel = {3'b000, direction_select_flag_second,
		direction_select_flag_first};
	// pair A drives the first quadrature counter
	// pair B drives the reset-capable one and its variant
	assign four_edge = {edge_mode_flag_pair_b, edge_mode_flag_pair_a,
		3'b000};

	// wider gap for soft counters once zone or table is in use
	assign min_gap = freq_limited_r ?
		hsc_pkg::SW_LIMITED_GAP_CYC : hsc_pkg::SW_GAP_CYC;

	// Software or hardware operation of each counter
	always_comb begin
		sw_nxt[hsc_pkg::CTR_FIRST] = ~alt_first;
		sw_nxt[hsc_pkg::CTR_SECOND] = ~alt_second;
		sw_nxt[hsc_pkg::CTR_DUAL] = ~alt_dual;
		// compare on a hardware counter demotes it
		sw_nxt[hsc_pkg::CTR_QUAD] = cmp_target_r[hsc_pkg::CTR_QUAD];
		sw_nxt[hsc_pkg::CTR_QUAD_RST] = alt_dual | rst_inv |
			cmp_target_r[hsc_pkg::CTR_QUAD_RST];
		if (alt_first)
			sw_nxt[hsc_pkg::CTR_FIRST] = cmp_target_r[hsc_pkg::CTR_FIRST];
		if (alt_second)
			sw_nxt[hsc_pkg::CTR_SECOND] =
				cmp_target_r[hsc_pkg::CTR_SECOND];
		if (alt_dual)
			sw_nxt[hsc_pkg::CTR_DUAL] = cmp_target_r[hsc_pkg::CTR_DUAL];
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			sw_mode_r <= 5'b00111;
		else
			sw_mode_r <= sw_nxt;
	end

	// ==========================================================
	// Counters
	genvar gi;
	generate
		for (gi = 0; gi < hsc_pkg::NUM_CTR; gi = gi + 1) begin : g_ctr
			counter_unit u_ctr (
				.sys_clk(sys_clk),
				.resetn(resetn),
				.route(route[gi]),
				.pins(ctr_pins),
				.enable(ctr_enable[gi]),
				.is_sw(sw_mode_r[gi]),
				.rst_inv(rst_inv),
				.dir_down_sel(dir_sel[gi]),
				.four_edge(four_edge[gi]),
				.min_gap(min_gap),
				.refresh(out_instr[gi] | current_value_fetch_instr[gi]),
				.live_r(live[gi]),
				.vis_r(cur_value[gi]),
				.step_r(step[gi]),
				.dir_down_r(dir_dn[gi])
			);
		end
	endgenerate

	// monitor flags off while up, on while down
	assign direction_monitor_flag_dual = dir_dn[hsc_pkg::CTR_DUAL];
	assign direction_monitor_flag_quad = dir_dn[hsc_pkg::CTR_QUAD];
	assign direction_monitor_flag_quad_reset =
		dir_dn[hsc_pkg::CTR_QUAD_RST];

	// ==========================================================
	// Compare loading
	// refuse a 33rd entry or a second table compare
	assign accept = cmp_load & ~run_start &
		(ld_ptr_r < hsc_pkg::SLOT_LIMIT) &
		~((cmp_req.kind == hsc_pkg::KIND_TABLE) & table_used_r) &
		(cmp_req.ctr < 3'(hsc_pkg::NUM_CTR));

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			run_q <= 1'b0;
			ld_ptr_r <= 6'h00;
			table_used_r <= 1'b0;
			cmp_refused_r <= 1'b0;
		end else begin
			run_q <= plc_run;
			cmp_refused_r <= cmp_load & ~accept;
			if (run_start) begin
				ld_ptr_r <= 6'h00;
				table_used_r <= 1'b0;
			end else if (accept) begin
				ld_ptr_r <= ld_ptr_r + 6'h01;
				if (cmp_req.kind == hsc_pkg::KIND_TABLE)
					table_used_r <= 1'b1;
			end
		end
	end

	// remember which counters carry a high-speed compare
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cmp_target_r <= 5'b00000;
			freq_limited_r <= 1'b0;
		end else if (run_start) begin
			cmp_target_r <= 5'b00000;
			freq_limited_r <= 1'b0;
		end else if (accept) begin
			cmp_target_r[cmp_req.ctr] <= 1'b1;
			// zone or table use limits soft counters
			if (cmp_req.kind == hsc_pkg::KIND_ZONE ||
				cmp_req.kind == hsc_pkg::KIND_TABLE)
				freq_limited_r <= 1'b1;
		end
	end

	// ==========================================================
	// Compare slots
	generate
		for (gi = 0; gi < hsc_pkg::NUM_SLOT; gi = gi + 1) begin : g_slot
			compare_slot u_slot (
				.sys_clk(sys_clk),
				.resetn(resetn),
				.load(accept && ld_ptr_r == 6'(gi)),
				.clear(run_start),
				.req(cmp_req),
				.value(live[slot_ent[gi].ctr]),
				.step(step[slot_ent[gi].ctr]),
				.used_r(slot_used[gi]),
				.ent_r(slot_ent[gi]),
				.drv_mask(slot_mask[gi]),
				.drv_val(slot_val[gi])
			);
		end
	endgenerate

	// Later slots win when two entries hit the same relay at once
	always_comb begin
		mask_any = 16'h0000;
		val_any = 16'h0000;
		for (int i = 0; i < hsc_pkg::NUM_SLOT; i++) begin
			val_any = (val_any & ~slot_mask[i]) |
				(slot_val[i] & slot_mask[i]);
			mask_any = mask_any | slot_mask[i];
		end
	end

	// relays change at once, not at the scan refresh
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			out_relay_r <= 16'h0000;
		else
			out_relay_r <= (out_relay_r & ~mask_any) | (val_any & mask_any);
	end

	// ==========================================================
	// Operation status
	// one sticky flag per shared channel
	// cleared at stop to run, a software counter re-sets it
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			op_status_flag_channel0 <= 1'b0;
			op_status_flag_channel2 <= 1'b0;
			op_status_flag_channel3 <= 1'b0;
		end else begin
			op_status_flag_channel0 <= (op_status_flag_channel0 &
				~run_start) |
				(ctr_enable[hsc_pkg::CTR_FIRST] & ~alt_first &
				sw_mode_r[hsc_pkg::CTR_FIRST]) |
				(ctr_enable[hsc_pkg::CTR_QUAD] &
				sw_mode_r[hsc_pkg::CTR_QUAD]);
			op_status_flag_channel2 <= (op_status_flag_channel2 &
				~run_start) |
				(ctr_enable[hsc_pkg::CTR_SECOND] & ~alt_second &
				sw_mode_r[hsc_pkg::CTR_SECOND]);
			op_status_flag_channel3 <= (op_status_flag_channel3 &
				~run_start) |
				(ctr_enable[hsc_pkg::CTR_DUAL] &
				sw_mode_r[hsc_pkg::CTR_DUAL]) |
				(ctr_enable[hsc_pkg::CTR_QUAD_RST] &
				sw_mode_r[hsc_pkg::CTR_QUAD_RST]);
		end
	end

endmodule

// ---- bench/pulse_source.sv ----
// Pulse source model on the counter input terminals.
// Assumes the bench calls its tasks; pins move at falling edges.
`timescale 1ns/1ps
module pulse_source (
	input wire logic sys_clk,
	output logic [7:0] ctr_pins
);
	initial ctr_pins = 8'h00;

	// ==========================================
	// Pin tasks
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic set_pin(input int p, input logic v);
		@(negedge sys_clk);
		ctr_pins[p] = v;
	endtask

	// Rises 26 cycles apart, clear of the limited soft gap
	task automatic pulse(input int p);
		set_pin(p, 1'b1);
		wait_cyc(12);
		set_pin(p, 1'b0);
		wait_cyc(12);
	endtask

	// Full quadrature cycle; the leading phase sets the direction
	task automatic quad(input int a, input int b, input logic up);
		int f;
		int s;
		f = up ? a : b;
		s = up ? b : a;
		set_pin(f, 1'b1);
		wait_cyc(12);
		set_pin(s, 1'b1);
		wait_cyc(12);
		set_pin(f, 1'b0);
		wait_cyc(12);
		set_pin(s, 1'b0);
		wait_cyc(12);
	endtask
endmodule

// ---- bench/high_speed_counter_control_sva.sv ----
// Port assertions for the high-speed counter bank.
// Assumes one clock domain and the active-low async reset.
`timescale 1ns/1ps
module high_speed_counter_control_sva (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] ctr_pins,
	input wire logic plc_run,
	input wire logic function_change_master_flag,
	input wire logic reset_polarity_flag,
	input wire logic edge_mode_flag_pair_a,
	input wire logic [4:0] ctr_enable,
	input wire logic [4:0] out_instr,
	input wire logic [4:0] current_value_fetch_instr,
	input wire logic cmp_load,
	input hsc_pkg::cmp_req_t cmp_req,
	input wire logic [4:0][31:0] cur_value,
	input wire logic direction_monitor_flag_quad,
	input wire logic op_status_flag_channel0,
	input wire logic op_status_flag_channel3,
	input wire logic [4:0] sw_mode_r,
	input wire logic freq_limited_r,
	input wire logic cmp_refused_r
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// ==========================================
	// Assertions
	hw_value_hold_a: assert property (
		!sw_mode_r[3] && !$past(sw_mode_r[3]) && $changed(cur_value[3])
		|-> $past(out_instr[3] || current_value_fetch_instr[3]))
		else $error("hw value moved without fetch");
	quad_dir_a: assert property (
		ctr_enable[3] && !sw_mode_r[3] && !edge_mode_flag_pair_a &&
		$rose(ctr_pins[0]) |=> direction_monitor_flag_quad == $past(ctr_pins[1]))
		else $error("quad direction flag wrong");
	status_set_a: assert property (
		ctr_enable[0] && sw_mode_r[0] |-> ##[1:2] op_status_flag_channel0)
		else $error("status flag not set");
	status_clear_a: assert property (
		$rose(plc_run) && ctr_enable == 5'h00 && $past(ctr_enable) == 5'h00
		|=> !op_status_flag_channel0 && !op_status_flag_channel3)
		else $error("status flags not cleared");
	pol_forces_sw_a: assert property (
		(function_change_master_flag && reset_polarity_flag) [*2]
		|-> sw_mode_r[4])
		else $error("inverted polarity left counter hw");
	cmp_to_sw_a: assert property (
		cmp_load && cmp_req.ctr == 3'h3 ##1 !cmp_refused_r |=> sw_mode_r[3])
		else $error("compare left counter hw");
	refuse_cause_a: assert property (
		cmp_refused_r |-> $past(cmp_load))
		else $error("refusal without load");
	limit_cause_a: assert property (
		$rose(freq_limited_r) |->
		$past(cmp_load && (cmp_req.kind[2] || cmp_req.kind[3])) ||
		$past(cmp_load && (cmp_req.kind[2] || cmp_req.kind[3]), 2))
		else $error("rate limit without zone or table");
	limit_hold_a: assert property (
		freq_limited_r && !$rose(plc_run) |=> freq_limited_r)
		else $error("rate limit dropped");
endmodule

bind high_speed_counter_control high_speed_counter_control_sva chk_i (
	.sys_clk, .resetn, .ctr_pins, .plc_run, .function_change_master_flag,
	.reset_polarity_flag, .edge_mode_flag_pair_a, .ctr_enable, .out_instr,
	.current_value_fetch_instr, .cmp_load, .cmp_req, .cur_value,
	.direction_monitor_flag_quad, .op_status_flag_channel0,
	.op_status_flag_channel3, .sw_mode_r, .freq_limited_r, .cmp_refused_r
);

// ---- bench/high_speed_counter_control_tb.sv ----
// Self-checking bench for the high-speed counter bank.
// Assumes pulse_source drives the pins and the checker is bound.
`timescale 1ns/1ps
module high_speed_counter_control_tb;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] ctr_pins;
	logic plc_run = 1'b1;
	logic function_change_master_flag = 1'b0;
	logic reset_polarity_flag = 1'b0;
	logic first_started_counter_switch = 1'b0;
	logic second_started_counter_switch = 1'b0;
	logic dual_counter_switch = 1'b0;
	logic edge_mode_flag_pair_a = 1'b0;
	logic edge_mode_flag_pair_b = 1'b0;
	logic direction_select_flag_first = 1'b0;
	logic direction_select_flag_second = 1'b0;
	logic [4:0] ctr_enable = 5'h00;
	logic [4:0] out_instr = 5'h00;
	logic [4:0] current_value_fetch_instr = 5'h00;
	logic cmp_load = 1'b0;
	hsc_pkg::cmp_req_t cmp_req = '0;
	logic [4:0][31:0] cur_value;
	logic [15:0] out_relay_r;
	logic direction_monitor_flag_dual, direction_monitor_flag_quad;
	logic direction_monitor_flag_quad_reset, op_status_flag_channel0;
	logic op_status_flag_channel2, op_status_flag_channel3;
	logic [4:0] sw_mode_r;
	logic freq_limited_r, cmp_refused_r, rf;
	int miscompares = 0;
	int n_checks = 0;
	int n, r;

	always #5 sys_clk = ~sys_clk;

	high_speed_counter_control dut (.sys_clk, .resetn, .ctr_pins, .plc_run,
		.function_change_master_flag, .reset_polarity_flag,
		.first_started_counter_switch, .second_started_counter_switch,
		.dual_counter_switch, .edge_mode_flag_pair_a, .edge_mode_flag_pair_b,
		.direction_select_flag_first, .direction_select_flag_second,
		.ctr_enable, .out_instr, .current_value_fetch_instr, .cmp_load,
		.cmp_req, .cur_value, .out_relay_r, .direction_monitor_flag_dual,
		.direction_monitor_flag_quad, .direction_monitor_flag_quad_reset,
		.op_status_flag_channel0, .op_status_flag_channel2,
		.op_status_flag_channel3, .sw_mode_r, .freq_limited_r, .cmp_refused_r);
	pulse_source src (.sys_clk(sys_clk), .ctr_pins(ctr_pins));

	// ==========================================
	// Helpers
	function automatic logic [31:0] net_count(input int up, input int dn);
		return 32'(up - dn);
	endfunction

	function automatic logic [31:0] zone_bits(input int v, lo, hi);
		return (v < lo) ? 32'h1 : (v > hi) ? 32'h4 : 32'h2;
	endfunction

	task automatic chk(input string w, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic strobe(input int c, input logic fetch);
		@(negedge sys_clk);
		if (fetch)
			current_value_fetch_instr[c] = 1'b1;
		else
			out_instr[c] = 1'b1;
		@(negedge sys_clk);
		current_value_fetch_instr = 5'h00;
		out_instr = 5'h00;
		src.wait_cyc(2);
	endtask

	// Refusal is caught over the two cycles after the load
	task automatic load(input hsc_pkg::cmp_kind_t k, input logic [2:0] c,
		input logic [3:0] rl, input logic [31:0] lo, hi, output logic rfd);
		@(negedge sys_clk);
		cmp_load = 1'b1;
		cmp_req = '{k, c, rl, lo, hi};
		@(negedge sys_clk);
		cmp_load = 1'b0;
		rfd = cmp_refused_r;
		@(negedge sys_clk);
		rfd = rfd | cmp_refused_r;
	endtask

	initial begin
		#100000;
		miscompares++;
		complete_run;
	end

	// ==========================================
	// Scenarios
	initial begin
		r = $urandom(59);
		repeat (8) @(negedge sys_clk);
		resetn = 1'b1;
		@(negedge sys_clk);
		chk("sw_mode", 32'(5'b00111), 32'(sw_mode_r));
		chk("relays", 32'h0, 32'(out_relay_r));
		ctr_enable = 5'b00101;
		src.set_pin(6, 1'b1);
		n = $urandom_range(6, 1);
		r = $urandom_range(n, 0);
		repeat (n) src.pulse(0);
		direction_select_flag_first = 1'b1;
		repeat (r) src.pulse(0);
		direction_select_flag_first = 1'b0;
		chk("count0", net_count(n, r), cur_value[0]);
		chk("status0", 32'h1, 32'(op_status_flag_channel0));
		chk("status3", 32'h1, 32'(op_status_flag_channel3));
		chk("status2", 32'h0, 32'(op_status_flag_channel2));
		src.pulse(1);
		chk("ext_clear", 32'h0, cur_value[0]);
		function_change_master_flag = 1'b1;
		reset_polarity_flag = 1'b1;
		repeat (3) src.pulse(0);
		src.set_pin(1, 1'b1);
		src.wait_cyc(3);
		chk("inv_hold", 32'h3, cur_value[0]);
		chk("quad_rst_sw", 32'h1, 32'(sw_mode_r[4]));
		src.set_pin(1, 1'b0);
		src.wait_cyc(3);
		chk("inv_clear", 32'h0, cur_value[0]);
		reset_polarity_flag = 1'b0;
		first_started_counter_switch = 1'b1;
		second_started_counter_switch = 1'b1;
		dual_counter_switch = 1'b1;
		src.set_pin(6, 1'b0);
		chk("switched", 32'(5'b10000), 32'(sw_mode_r));
		repeat (2) src.pulse(6);
		chk("hw0_hold", 32'h0, cur_value[0]);
		strobe(0, 1'b1);
		chk("hw0_fetch", 32'h2, cur_value[0]);
		function_change_master_flag = 1'b0;
		src.wait_cyc(3);
		chk("master_gate", 32'(5'b00111), 32'(sw_mode_r));
		{first_started_counter_switch, second_started_counter_switch} = 2'b00;
		dual_counter_switch = 1'b0;
		ctr_enable = 5'b01000;
		repeat (3) src.quad(0, 1, 1'b1);
		src.quad(0, 1, 1'b0);
		chk("hw3_hold", 32'h0, cur_value[3]);
		strobe(3, 1'b1);
		chk("hw3_fetch", net_count(3, 1), cur_value[3]);
		edge_mode_flag_pair_a = 1'b1;
		repeat (2) src.quad(0, 1, 1'b1);
		src.quad(0, 1, 1'b0);
		chk("dir_down", 32'h1, 32'(direction_monitor_flag_quad));
		strobe(3, 1'b0);
		chk("four_edge", net_count(10, 4), cur_value[3]);
		edge_mode_flag_pair_a = 1'b0;
		r = $urandom_range(12, 0);
		load(hsc_pkg::KIND_SET, 3'h3, 4'(r), 32'h8, 32'h0, rf);
		chk("set_taken", 32'h0, 32'(rf));
		chk("cmp_sw", 32'h1, 32'(sw_mode_r[3]));
		repeat (2) src.quad(0, 1, 1'b1);
		chk("set_relay", 32'h1, 32'(out_relay_r[r]));
		chk("soft3", 32'h8, cur_value[3]);
		load(hsc_pkg::KIND_RESET, 3'h3, 4'(r), 32'h9, 32'h0, rf);
		load(hsc_pkg::KIND_ZONE, 3'h3, 4'hd, 32'h0, 32'h64, rf);
		chk("limited", 32'h1, 32'(freq_limited_r));
		src.quad(0, 1, 1'b1);
		chk("reset_relay", 32'h0, 32'(out_relay_r[r]));
		chk("zone", zone_bits(9, 0, 100), 32'(out_relay_r[15:13]));
		load(hsc_pkg::KIND_TABLE, 3'h3, 4'(r), 32'h64, 32'h65, rf);
		chk("table1", 32'h0, 32'(rf));
		load(hsc_pkg::KIND_TABLE, 3'h3, 4'(r), 32'h64, 32'h65, rf);
		chk("table2", 32'h1, 32'(rf));
		ctr_enable = 5'h00;
		plc_run = 1'b0;
		src.wait_cyc(3);
		plc_run = 1'b1;
		src.wait_cyc(3);
		chk("run_clear", 32'h0, 32'({op_status_flag_channel0,
			op_status_flag_channel3, freq_limited_r}));
		chk("targets", 32'(5'b00111), 32'(sw_mode_r));
		ctr_enable = 5'b10110;
		{direction_select_flag_second, edge_mode_flag_pair_b} = 2'($urandom);
		src.set_pin(7, 1'b1);
		n = $urandom_range(4, 1);
		repeat (n) src.pulse(2);
		chk("count1", 32'(direction_select_flag_second ? -n : n),
			cur_value[1]);
		chk("status2_on", 32'h1, 32'(op_status_flag_channel2));
		r = $urandom_range(1, 0);
		repeat (n) src.quad(3, 4, r[0]);
		strobe(4, r[0]);
		chk("count4", 32'((r ? n : -n) * (edge_mode_flag_pair_b ? 4 : 1)),
			cur_value[4]);
		chk("dir4", 32'(r == 0),
			32'(direction_monitor_flag_quad_reset));
		chk("dir2", 32'(r), 32'(direction_monitor_flag_dual));
		n = 0;
		repeat (32) begin
			// Master stays off, so scrambled flags must not block loads
			{out_instr, direction_select_flag_first, reset_polarity_flag,
				first_started_counter_switch, dual_counter_switch,
				second_started_counter_switch, edge_mode_flag_pair_a,
				ctr_enable} = 16'($urandom);
			load(hsc_pkg::KIND_SET, 3'($urandom_range(4, 0)), 4'($urandom),
				$urandom, 32'h0, rf);
			n = n + int'(rf);
		end
		chk("slots", 32'h0, 32'(n));
		load(hsc_pkg::KIND_SET, 3'h0, 4'h0, 32'h0, 32'h0, rf);
		chk("slot_full", 32'h1, 32'(rf));
		complete_run;
	end
endmodule
